// [alf_pkg.sv]
package alf_pkg;
    // Instruction word layout
    localparam int INSTR_W = 14;
    localparam int TOP_HI = 13;
    localparam int TOP_LO = 12;
    localparam int OPC_HI = 11;
    localparam int OPC_LO = 8;
    localparam int TARGET_BIT = 7;
    localparam int INDEX_HI = 6;
    localparam int LIT_HI = 7;
    localparam int DATA_W = 8;
    localparam int INDEX_W = 7;
    localparam int NIBBLE_W = 4;
    localparam int FILE_DEPTH = 128;

    // Encodings of the two supported instructions
    localparam logic [1:0] TOP_LITERAL = 2'h3;
    localparam logic [3:0] OPC_AND_LITERAL = 4'h9;
    localparam logic [1:0] TOP_BYTE_FILE = 2'h0;
    localparam logic [3:0] OPC_ADD_FILE = 4'h7;
    localparam logic TARGET_ACC = 1'h0;
    localparam logic TARGET_FILE = 1'h1;

    // Reset values
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'h0;

    typedef enum logic [3:0] {
        ALF_PH_DECODE = 4'h1,
        ALF_PH_READ = 4'h2,
        ALF_PH_PROCESS = 4'h4,
        ALF_PH_WRITE = 4'h8
    } alf_phase_t;

    typedef enum logic [2:0] {
        ALF_OP_NONE = 3'h1,
        ALF_OP_AND_LIT = 3'h2,
        ALF_OP_ADD_FILE = 3'h4
    } alf_op_t;
endpackage

// [alf_rf_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface alf_rf_if;
    logic [alf_pkg::INDEX_W-1:0] rd_index;
    logic [alf_pkg::DATA_W-1:0] rd_data;
    logic wr_en;
    logic [alf_pkg::INDEX_W-1:0] wr_index;
    logic [alf_pkg::DATA_W-1:0] wr_data;
    logic [alf_pkg::INDEX_W-1:0] peek_index;
    logic [alf_pkg::DATA_W-1:0] peek_data;

    modport core (
        output rd_index,
        output wr_en,
        output wr_index,
        output wr_data,
        output peek_index,
        input rd_data,
        input peek_data
    );
    modport store (
        input rd_index,
        input wr_en,
        input wr_index,
        input wr_data,
        input peek_index,
        output rd_data,
        output peek_data
    );
endinterface
`default_nettype wire

// [alf_regfile.sv]
`timescale 1ns/1ps
`default_nettype none
module alf_regfile (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Core side
    alf_rf_if.store rf
);
    typedef struct packed {
        logic [alf_pkg::FILE_DEPTH-1:0][alf_pkg::DATA_W-1:0] mem;
    } alf_rf_state_t;

    alf_rf_state_t q, d;

    always_comb begin
        d = q;
        if (rf.wr_en) begin
            d.mem[rf.wr_index] = rf.wr_data;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q <= '{mem: {alf_pkg::FILE_DEPTH{alf_pkg::FILE_RESET}}};
        end else begin
            q <= d;
        end
    end

    assign rf.rd_data = q.mem[rf.rd_index];
    assign rf.peek_data = q.mem[rf.peek_index];

    chk_file_write_lands: assert property (@(posedge clock) disable iff (!rstn)
        rf.wr_en |=> q.mem[$past(rf.wr_index)] == $past(rf.wr_data))
        else $error("file write did not land");
endmodule
`default_nettype wire

// [alf_core.sv]
`timescale 1ns/1ps
`default_nettype none
module alf_core (
    // Clock and reset
    input wire logic clock,
    input wire logic rstn,
    // Instruction from the fetch stage, sampled in the decode phase
    input wire logic instr_valid,
    input wire logic [alf_pkg::INSTR_W-1:0] instr_word,
    // Accumulator preload, taken in the decode phase
    input wire logic acc_load_valid,
    input wire logic [alf_pkg::DATA_W-1:0] acc_load_data,
    // File preload, lost when the core writes the same cycle
    input wire logic file_load_valid,
    input wire logic [alf_pkg::INDEX_W-1:0] file_load_index,
    input wire logic [alf_pkg::DATA_W-1:0] file_load_data,
    // File observation
    input wire logic [alf_pkg::INDEX_W-1:0] peek_index,
    output logic [alf_pkg::DATA_W-1:0] peek_data,
    // Architectural state
    output logic [alf_pkg::DATA_W-1:0] accumulator,
    output logic overflow_out_bit,
    output logic nibble_overflow_bit,
    output logic result_null_flag,
    // Sequencing
    output logic decode_phase,
    output logic retire
);
    typedef struct packed {
        alf_pkg::alf_phase_t phase;
        alf_pkg::alf_op_t op;
        logic target;
        logic [alf_pkg::INDEX_W-1:0] index;
        logic [alf_pkg::DATA_W-1:0] literal;
        logic [alf_pkg::DATA_W-1:0] operand;
        logic [alf_pkg::DATA_W-1:0] result;
        logic carry_new;
        logic nibble_new;
        logic acc_a;
        logic [alf_pkg::DATA_W-1:0] acc;
        logic carry;
        logic nibble;
        logic zero;
        logic retire;
        logic [alf_pkg::DATA_W-1:0] peek;
    } alf_core_state_t;

    localparam alf_core_state_t STATE_RESET = '{
        phase: alf_pkg::ALF_PH_DECODE,
        op: alf_pkg::ALF_OP_NONE,
        target: alf_pkg::TARGET_ACC,
        index: 7'h00,
        literal: 8'h00,
        operand: 8'h00,
        result: 8'h00,
        carry_new: alf_pkg::FLAG_RESET,
        nibble_new: alf_pkg::FLAG_RESET,
        acc_a: 1'h0,
        acc: alf_pkg::ACC_RESET,
        carry: alf_pkg::FLAG_RESET,
        nibble: alf_pkg::FLAG_RESET,
        zero: alf_pkg::FLAG_RESET,
        retire: 1'h0,
        peek: 8'h00
    };

    alf_core_state_t q, d;
    alf_rf_if rf ();
    logic core_wr;
    logic [alf_pkg::DATA_W:0] full_sum;
    logic [alf_pkg::NIBBLE_W:0] low_sum;

    alf_regfile u_regfile (
        .clock(clock),
        .rstn(rstn),
        .rf(rf.store)
    );

    assign core_wr = (q.phase == alf_pkg::ALF_PH_WRITE) && (q.op == alf_pkg::ALF_OP_ADD_FILE)
                     && (q.target == alf_pkg::TARGET_FILE);
    assign rf.rd_index = q.index;
    assign rf.wr_en = core_wr || file_load_valid;
    assign rf.wr_index = core_wr ? q.index : file_load_index;
    assign rf.wr_data = core_wr ? q.result : file_load_data;
    assign rf.peek_index = peek_index;

    assign full_sum = {1'b0, q.acc} + {1'b0, q.operand};
    assign low_sum = {1'b0, q.acc[alf_pkg::NIBBLE_W-1:0]} + {1'b0, q.operand[alf_pkg::NIBBLE_W-1:0]};

    always_comb begin
        d = q;
        d.retire = 1'b0;
        d.peek = rf.peek_data;
        case (q.phase)
            alf_pkg::ALF_PH_DECODE: begin
                d.phase = alf_pkg::ALF_PH_READ;
                d.op = alf_pkg::ALF_OP_NONE;
                if (instr_valid && instr_word[alf_pkg::TOP_HI:alf_pkg::TOP_LO] == alf_pkg::TOP_LITERAL
                    && instr_word[alf_pkg::OPC_HI:alf_pkg::OPC_LO] == alf_pkg::OPC_AND_LITERAL) begin
                    d.op = alf_pkg::ALF_OP_AND_LIT;
                end else if (instr_valid && instr_word[alf_pkg::TOP_HI:alf_pkg::TOP_LO] == alf_pkg::TOP_BYTE_FILE
                    && instr_word[alf_pkg::OPC_HI:alf_pkg::OPC_LO] == alf_pkg::OPC_ADD_FILE) begin
                    d.op = alf_pkg::ALF_OP_ADD_FILE;
                end
                d.target = instr_word[alf_pkg::TARGET_BIT];
                d.index = instr_word[alf_pkg::INDEX_HI:0];
                d.literal = instr_word[alf_pkg::LIT_HI:0];
                if (acc_load_valid) begin
                    d.acc = acc_load_data;
                end
            end
            alf_pkg::ALF_PH_READ: begin
                d.phase = alf_pkg::ALF_PH_PROCESS;
                d.operand = (q.op == alf_pkg::ALF_OP_AND_LIT) ? q.literal : rf.rd_data;
            end
            alf_pkg::ALF_PH_PROCESS: begin
                d.phase = alf_pkg::ALF_PH_WRITE;
                if (q.op == alf_pkg::ALF_OP_AND_LIT) begin
                    d.result = q.acc & q.operand;
                end else begin
                    d.result = full_sum[alf_pkg::DATA_W-1:0];
                end
                d.carry_new = full_sum[alf_pkg::DATA_W];
                d.nibble_new = low_sum[alf_pkg::NIBBLE_W];
            end
            alf_pkg::ALF_PH_WRITE: begin
                d.phase = alf_pkg::ALF_PH_DECODE;
                d.retire = (q.op != alf_pkg::ALF_OP_NONE);
                if (q.op == alf_pkg::ALF_OP_AND_LIT) begin
                    d.acc = q.result;
                    d.zero = (q.result == 8'h00);
                end else if (q.op == alf_pkg::ALF_OP_ADD_FILE) begin
                    d.carry = q.carry_new;
                    d.nibble = q.nibble_new;
                    d.zero = (q.result == 8'h00);
                    if (q.target == alf_pkg::TARGET_ACC) begin
                        d.acc = q.result;
                    end
                end
            end
            default: begin
                d = STATE_RESET;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            q <= STATE_RESET;
        end else begin
            q <= d;
        end
    end

    assign accumulator = q.acc;
    assign overflow_out_bit = q.carry;
    assign nibble_overflow_bit = q.nibble;
    assign result_null_flag = q.zero;
    assign decode_phase = q.phase[0];
    assign retire = q.retire;
    assign peek_data = q.peek;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    chk_and_result_acc: assert property (
        (q.phase == alf_pkg::ALF_PH_PROCESS && q.op == alf_pkg::ALF_OP_AND_LIT)
        |=> ##1 q.acc == ($past(q.acc, 2) & $past(q.literal, 2)))
        else $error("and result wrong in accumulator");
    chk_and_flags_only: assert property (
        (q.phase == alf_pkg::ALF_PH_WRITE && q.op == alf_pkg::ALF_OP_AND_LIT)
        |=> result_null_flag == (accumulator == 8'h00) && $stable(overflow_out_bit)
            && $stable(nibble_overflow_bit))
        else $error("and changed wrong flags");
    // Sum rebuilt from the operands, not from the adder nets
    chk_add_flags_sum: assert property (
        (q.phase == alf_pkg::ALF_PH_PROCESS && q.op == alf_pkg::ALF_OP_ADD_FILE)
        |=> ##1 {overflow_out_bit, $past(q.result)}
                == ({1'b0, $past(q.acc, 2)} + {1'b0, $past(q.operand, 2)})
            && nibble_overflow_bit
                == (({1'b0, $past(q.acc[alf_pkg::NIBBLE_W-1:0], 2)}
                    + {1'b0, $past(q.operand[alf_pkg::NIBBLE_W-1:0], 2)}) > 5'h0f)
            && result_null_flag == ($past(q.result) == 8'h00))
        else $error("add flags wrong");
    chk_add_to_acc: assert property (
        (q.phase == alf_pkg::ALF_PH_WRITE && q.op == alf_pkg::ALF_OP_ADD_FILE && q.target == alf_pkg::TARGET_ACC)
        |-> !rf.wr_en || rf.wr_index != q.index ##1 q.acc == $past(q.result))
        else $error("add to accumulator wrong");
    chk_add_keeps_acc: assert property (
        (q.phase == alf_pkg::ALF_PH_WRITE && q.op == alf_pkg::ALF_OP_ADD_FILE && q.target == alf_pkg::TARGET_FILE)
        |-> rf.wr_en && rf.wr_data == q.result ##1 $stable(q.acc))
        else $error("add to file disturbed accumulator");
    chk_phase_order: assert property (
        q.phase == alf_pkg::ALF_PH_DECODE |=> q.phase == alf_pkg::ALF_PH_READ
        ##1 q.phase == alf_pkg::ALF_PH_PROCESS ##1 q.phase == alf_pkg::ALF_PH_WRITE
        ##1 q.phase == alf_pkg::ALF_PH_DECODE)
        else $error("phase order broken");
    chk_decode_rejects: assert property (
        (q.phase == alf_pkg::ALF_PH_DECODE
            && instr_valid
            && instr_word[alf_pkg::TOP_HI:alf_pkg::OPC_LO] != {alf_pkg::TOP_LITERAL, alf_pkg::OPC_AND_LITERAL}
            && instr_word[alf_pkg::TOP_HI:alf_pkg::OPC_LO] != {alf_pkg::TOP_BYTE_FILE, alf_pkg::OPC_ADD_FILE})
        |=> q.op == alf_pkg::ALF_OP_NONE)
        else $error("unsupported encoding decoded");
    chk_noop_quiet: assert property (
        (q.phase == alf_pkg::ALF_PH_WRITE && q.op == alf_pkg::ALF_OP_NONE)
        |=> !q.retire
            && $stable(q.acc)
            && $stable(q.carry) && $stable(q.nibble) && $stable(q.zero))
        else $error("no-op changed state");
    chk_retire_pulse: assert property (
        q.retire |=> !q.retire)
        else $error("retire longer than one cycle");

    cov_and_literal: cover property (q.retire && $past(q.op) == alf_pkg::ALF_OP_AND_LIT);
    cov_add_to_acc: cover property (q.phase == alf_pkg::ALF_PH_WRITE && q.op == alf_pkg::ALF_OP_ADD_FILE
        && q.target == alf_pkg::TARGET_ACC && q.carry_new);
    cov_add_to_file: cover property (core_wr && q.nibble_new);
    cov_late_offer: cover property (instr_valid && q.phase != alf_pkg::ALF_PH_DECODE);
    cov_noop_write: cover property (q.phase == alf_pkg::ALF_PH_WRITE && q.op == alf_pkg::ALF_OP_NONE
        && $past(instr_valid, 3));
endmodule
`default_nettype wire

// [and_literal_add_file_alu_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module and_literal_add_file_alu_tb_top;
    typedef struct packed {
        logic [7:0] acc;
        logic c;
        logic dc;
        logic z;
        logic [31:0] cyc;
    } alf_note_t;

    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic instr_valid = 1'b0;
    logic [alf_pkg::INSTR_W-1:0] instr_word = 14'h0000;
    logic acc_load_valid = 1'b0;
    logic [alf_pkg::DATA_W-1:0] acc_load_data = 8'h00;
    logic file_load_valid = 1'b0;
    logic [alf_pkg::INDEX_W-1:0] file_load_index = 7'h00;
    logic [alf_pkg::DATA_W-1:0] file_load_data = 8'h00;
    logic [alf_pkg::INDEX_W-1:0] peek_index = 7'h00;
    logic [alf_pkg::DATA_W-1:0] peek_data;
    logic [alf_pkg::DATA_W-1:0] accumulator;
    logic overflow_out_bit;
    logic nibble_overflow_bit;
    logic result_null_flag;
    logic decode_phase;
    logic retire;
    int num_errors = 0;
    int checks_done = 0;
    logic [31:0] cyc = 32'h0;
    logic [7:0] m_acc;
    logic [7:0] m_file [128];
    logic m_c;
    logic m_dc;
    logic m_z;
    alf_note_t notes [$];
    alf_note_t n;

    alf_core dut_u (
        .clock(clock), .rstn(rstn), .instr_valid(instr_valid), .instr_word(instr_word),
        .acc_load_valid(acc_load_valid), .acc_load_data(acc_load_data),
        .file_load_valid(file_load_valid), .file_load_index(file_load_index),
        .file_load_data(file_load_data), .peek_index(peek_index), .peek_data(peek_data),
        .accumulator(accumulator), .overflow_out_bit(overflow_out_bit),
        .nibble_overflow_bit(nibble_overflow_bit), .result_null_flag(result_null_flag),
        .decode_phase(decode_phase), .retire(retire)
    );

    always #25 clock = ~clock;

    task automatic conclude();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic step();
        @(posedge clock);
        #2;
    endtask

    task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic reset_model();
        m_acc = 8'h00;
        m_c = 1'b0;
        m_dc = 1'b0;
        m_z = 1'b0;
        for (int i = 0; i < 128; i++) begin
            m_file[i] = 8'h00;
        end
    endtask

    task automatic load_file(input logic [6:0] i, input logic [7:0] v);
        file_load_valid = 1'b1;
        file_load_index = i;
        file_load_data = v;
        m_file[i] = v;
        step();
    endtask

    task automatic peek(input logic [6:0] i);
        peek_index = i;
        step();
        step();
        chk_byte("file register", m_file[i], peek_data);
    endtask

    task automatic run(input logic [13:0] w, input logic ld, input logic [7:0] ldv);
        logic [8:0] s;
        logic [7:0] f;
        int k;
        k = 0;
        while (decode_phase !== 1'b1 && k < 8) begin
            step();
            k++;
        end
        instr_valid = 1'b1;
        instr_word = w;
        acc_load_valid = ld;
        acc_load_data = ldv;
        if (ld) m_acc = ldv;
        step();
        instr_valid = 1'b0;
        acc_load_valid = 1'b0;
        f = m_file[w[6:0]];
        if (w[13:8] == 6'h39) begin
            m_acc = m_acc & w[7:0];
            m_z = (m_acc == 8'h00);
            notes.push_back('{m_acc, m_c, m_dc, m_z, cyc + 32'h3});
        end else if (w[13:8] == 6'h07) begin
            s = {1'b0, m_acc} + {1'b0, f};
            m_c = s[8];
            m_dc = ({1'b0, m_acc[3:0]} + {1'b0, f[3:0]}) > 5'h0f;
            m_z = (s[7:0] == 8'h00);
            if (w[7]) m_file[w[6:0]] = s[7:0];
            else m_acc = s[7:0];
            notes.push_back('{m_acc, m_c, m_dc, m_z, cyc + 32'h3});
        end
    endtask

    always @(posedge clock) begin
        cyc <= cyc + 32'h1;
        if (cyc == 32'd6000) begin
            num_errors++;
            $display("unexpected timeout: expected finish seen hang");
            conclude();
        end
    end

    // Result watcher
    always begin
        step();
        if (retire === 1'b1) begin
            if (notes.size() == 0) begin
                num_errors++;
                $display("unexpected retire: expected 0 seen 1");
            end else begin
                n = notes.pop_front();
                chk_byte("retire cycle", n.cyc[7:0], cyc[7:0]);
                chk_byte("accumulator", n.acc, accumulator);
                chk_bit("overflow_out_bit", n.c, overflow_out_bit);
                chk_bit("nibble_overflow_bit", n.dc, nibble_overflow_bit);
                chk_bit("result_null_flag", n.z, result_null_flag);
            end
        end
    end

    initial begin
        logic [31:0] r;
        logic [13:0] bad [6];
        bad = '{14'h3a5f, 14'h3e01, 14'h0504, 14'h0000, 14'h0f04, 14'h1904};
        void'($urandom(32'he0ec));
        reset_model();
        repeat (16) @(posedge clock);
        #2;
        chk_byte("reset accumulator", 8'h00, accumulator);
        chk_bit("reset decode_phase", 1'b1, decode_phase);
        chk_bit("reset retire", 1'b0, retire);
        rstn = 1'b1;
        load_file(7'h04, 8'hc2);
        load_file(7'h7f, 8'h01);
        r = $urandom;
        load_file(7'h00, r[7:0]);
        file_load_valid = 1'b0;
        peek(7'h04);
        run(14'h395f, 1'b1, 8'ha3);
        run(14'h0704, 1'b1, 8'h17);
        run(14'h0784, 1'b0, 8'h00);
        run(14'h07ff, 1'b1, 8'hff);
        run(14'h39ff, 1'b0, 8'h00);
        foreach (bad[i]) begin
            run(bad[i], 1'b0, 8'h00);
        end
        // Offered outside the decode phase, must be ignored
        step();
        instr_valid = 1'b1;
        instr_word = 14'h3900;
        step();
        instr_valid = 1'b0;
        run(14'h39f0, 1'b0, 8'h00);
        repeat (30) begin
            r = $urandom;
            if (r[1:0] == 2'h0) run({6'h39, r[15:8]}, r[2], r[31:24]);
            else run({6'h07, r[3], r[14:8]}, r[2], r[31:24]);
        end
        repeat (6) step();
        for (int i = 0; i < 128; i++) begin
            peek(i[6:0]);
        end
        run(14'h0784, 1'b1, 8'h55);
        rstn = 1'b0;
        step();
        notes.delete();
        reset_model();
        chk_byte("reset accumulator", 8'h00, accumulator);
        chk_bit("reset result_null_flag", 1'b0, result_null_flag);
        rstn = 1'b1;
        peek(7'h04);
        run(14'h0704, 1'b1, 8'h80);
        repeat (6) step();
        chk_byte("pending notes", 8'h00, 8'(notes.size()));
        conclude();
    end
endmodule
`default_nettype wire
